// file: rtl/mcd_decoder.sv
// Command decoder with accumulator, X register and vectored interrupt dispatch.

// How it works
// (RQ1) Motion opcodes 1,2,3,4,30,31,32 decode in both modes.
// (RQ2) Parameter opcodes 5 to 12 decode in both modes.
// (RQ3) Axis settings are per axis; module settings are kept apart.
// (RQ4) Flow opcodes 20 to 24, 27, 28 act only in standalone mode.
// (RQ5) Opcodes 14 and 15 drive or read I/O ports in either mode.
// (RQ6) Calculation opcodes 19, 33, 34, 35, 39 serve stored programs.
// (RQ7) Standalone value reads load the result into the accumulator.
// (RQ8) An X register holds extra data, loadable from the accumulator.
// (RQ9) Direct-mode reads return the value, accumulator untouched.
// (RQ10) Direct reads during a running program leave its flow unchanged.
// (RQ11) Interrupt opcodes 25, 26, 37, 38 are decoded.
// (RQ12) Each source keeps its own handler entry address.
// (RQ13) Sources are numbered 0-3, 15, 21, 27, 28, 39, 40; 255 is global.
// (RQ14) Dispatch needs event, enable and a valid handler address together.
// (RQ15) Accumulator, X register and flags are saved before a handler.
// (RQ16) No nesting: no dispatch while a handler runs.
// (RQ17) Return from handler restores context and resumes the program.
// (RQ18) Software enables globally with number 255 plus each source.
// (RQ19) Source settings come from module writes with bank 3.
// (RQ20) Lowest pending number is dispatched first; others stay pending.
module mcd_decoder #(
	parameter int ADDR_W = 16,
	parameter int AXES = 1
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_direct_in,
	input mcd_pkg::mcd_cmd_t cmd_in,
	input wire logic [31:0] read_data_in,
	input wire logic [ADDR_W-1:0] prog_pc_in,
	input wire logic [mcd_pkg::NUM_SRC-1:0] irq_event_in,
	output mcd_pkg::mcd_group_t group_out,
	output logic exec_out,
	output logic axis_write_out,
	output logic module_write_out,
	output logic src_setting_write_out,
	output logic [31:0] reply_value_out,
	output logic reply_valid_out,
	output logic [31:0] accu_out,
	output logic [31:0] xreg_out,
	output logic [7:0] flags_out,
	output logic divert_out,
	output logic [ADDR_W-1:0] divert_addr_out,
	output logic resume_out,
	output logic [ADDR_W-1:0] resume_addr_out,
	output logic in_handler_out
);

	localparam int N = mcd_pkg::NUM_SRC;
	localparam logic [7:0] FLAG_ZERO = 8'h01;
	localparam logic [7:0] FLAG_NEG = 8'h02;
	localparam logic [7:0] OPR_ADD = 8'h00;
	localparam logic [7:0] OPR_SUB = 8'h01;
	localparam logic [7:0] OPR_LOAD = 8'h02;
	localparam logic [7:0] OPR_XLOAD = 8'h03;

	// ****************************************
	// Decode
	// ****************************************
	mcd_pkg::mcd_group_t grp;
	mcd_pkg::mcd_attr_t attr;

	mcd_group_decode u_dec (
		.opcode_in(cmd_in.opcode),
		.group_out(grp),
		.attr_out(attr)
	);

	// Returns the source slot of an interrupt number, or SLOT_NONE.
	function automatic logic [3:0] slot_of(input logic [7:0] num);
		logic [3:0] s;
		s = mcd_pkg::SLOT_NONE;
		for (int i = 0; i < N; i++) begin
			if (mcd_pkg::IRQ_NUM[i] == num) begin
				s = 4'(i); // (RQ13)
			end
		end
		return s;
	endfunction

	wire logic is_op_take = cmd_valid_in;
	wire logic stand_cmd = is_op_take && !cmd_direct_in;
	wire logic good_cmd = is_op_take && grp != mcd_pkg::MCD_GRP_BAD;
	// Direct-mode flow commands are refused so a running program is not disturbed.
	wire logic act_cmd = good_cmd && !(cmd_direct_in && attr.standalone_only); // (RQ4) (RQ10)
	wire logic [3:0] cmd_slot = slot_of(cmd_in.kind);
	wire logic slot_ok = cmd_slot != mcd_pkg::SLOT_NONE;
	wire logic op_unmask = stand_cmd && cmd_in.opcode == mcd_pkg::OP_UNMASK_INTERRUPT_SOURCE;
	wire logic op_mask = stand_cmd && cmd_in.opcode == mcd_pkg::OP_MASK_INTERRUPT_SOURCE;
	wire logic op_set_handler_entry = stand_cmd && cmd_in.opcode == mcd_pkg::OP_SET_HANDLER_ENTRY;
	wire logic op_return_from_handler = stand_cmd && cmd_in.opcode == mcd_pkg::OP_RETURN_FROM_HANDLER;
	wire logic op_arith_with_constant = stand_cmd && cmd_in.opcode == mcd_pkg::OP_ARITH_WITH_CONSTANT;
	wire logic op_arith_with_x_register = stand_cmd && cmd_in.opcode == mcd_pkg::OP_ARITH_WITH_X_REGISTER;
	wire logic op_comp = stand_cmd && cmd_in.opcode == mcd_pkg::OP_TEST_AGAINST_CONSTANT;
	wire logic stand_read = stand_cmd && attr.reads_value;
	wire logic direct_read = is_op_take && cmd_direct_in && attr.reads_value;

	// ****************************************
	// Interrupt state
	// ****************************************
	logic [N-1:0] pend_reg;
	logic [N-1:0] enable_reg;
	logic [N-1:0] vec_ok_reg;
	logic [ADDR_W-1:0] vec_reg [N];
	logic global_en_reg;
	logic handler_reg;
	logic [ADDR_W-1:0] ret_pc_reg;
	mcd_pkg::mcd_context_t saved_reg;
	logic [31:0] accu_reg;
	logic [31:0] xreg_reg;
	logic [7:0] flags_reg;

	// Dispatch requires event, enable, vector and no running handler.
	wire logic [N-1:0] ready = pend_reg & enable_reg & vec_ok_reg; // (RQ14)
	wire logic pick_any;
	wire logic [3:0] pick_slot;

	mcd_irq_pick #(.N(N)) u_pick (
		.ready_in(ready),
		.any_out(pick_any),
		.slot_out(pick_slot)
	);

	// A program instruction in this cycle takes precedence; dispatch waits a slot.
	wire logic take_irq = pick_any && global_en_reg && !handler_reg && !stand_cmd; // (RQ16)

	// ****************************************
	// Calculation
	// ****************************************
	logic [31:0] arith_with_constant_res;
	logic [31:0] arith_with_constant_b;
	assign arith_with_constant_b = op_arith_with_x_register ? xreg_reg : cmd_in.value;
	always_comb begin
		case (cmd_in.kind)
			OPR_ADD: arith_with_constant_res = accu_reg + arith_with_constant_b;
			OPR_SUB: arith_with_constant_res = accu_reg - arith_with_constant_b;
			OPR_LOAD: arith_with_constant_res = arith_with_constant_b;
			default: arith_with_constant_res = accu_reg;
		endcase
	end
	wire logic xload = op_arith_with_x_register && cmd_in.kind == OPR_XLOAD;
	wire logic [31:0] cmp_diff = accu_reg - cmd_in.value;
	wire logic [7:0] cmp_flags = (cmp_diff == 32'h0 ? FLAG_ZERO : 8'h00)
		| (cmp_diff[31] ? FLAG_NEG : 8'h00);

	// ****************************************
	// Pending, enable and vector registers
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			wire logic hit = cmd_slot == 4'(g);
			wire logic served = take_irq && pick_slot == 4'(g);
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					pend_reg[g] <= 1'b0;
					enable_reg[g] <= 1'b0;
					vec_ok_reg[g] <= 1'b0;
					vec_reg[g] <= '0;
				end else begin
					// A new event in the dispatch cycle keeps the source pending.
					pend_reg[g] <= irq_event_in[g] || (pend_reg[g] && !served); // (RQ20)
					if (op_unmask && hit) enable_reg[g] <= 1'b1;
					else if (op_mask && hit) enable_reg[g] <= 1'b0;
					if (op_set_handler_entry && hit) begin
						vec_ok_reg[g] <= 1'b1;
						vec_reg[g] <= cmd_in.value[ADDR_W-1:0]; // (RQ12)
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Working registers and handler state
	// ****************************************
	mcd_pkg::mcd_context_t live_ctx;
	assign live_ctx = '{accu: accu_reg, xreg: xreg_reg, flags: flags_reg};
	logic [31:0] accu_next;
	logic [31:0] xreg_next;
	logic [7:0] flags_next;
	always_comb begin
		accu_next = accu_reg;
		xreg_next = xreg_reg;
		flags_next = flags_reg;
		if (op_return_from_handler && handler_reg) begin
			accu_next = saved_reg.accu; // (RQ17)
			xreg_next = saved_reg.xreg;
			flags_next = saved_reg.flags;
		end else if (xload) begin
			xreg_next = accu_reg; // (RQ8)
		end else if (op_arith_with_constant || op_arith_with_x_register) begin
			accu_next = arith_with_constant_res; // (RQ6)
			flags_next = (arith_with_constant_res == 32'h0 ? FLAG_ZERO : 8'h00)
				| (arith_with_constant_res[31] ? FLAG_NEG : 8'h00);
		end else if (op_comp) begin
			flags_next = cmp_flags;
		end else if (stand_read) begin
			accu_next = read_data_in; // (RQ7)
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			accu_reg <= '0;
			xreg_reg <= '0;
			flags_reg <= '0;
			global_en_reg <= 1'b0;
			handler_reg <= 1'b0;
			ret_pc_reg <= '0;
			saved_reg <= '0;
		end else begin
			accu_reg <= accu_next;
			xreg_reg <= xreg_next;
			flags_reg <= flags_next;
			if (op_unmask && cmd_in.kind == mcd_pkg::IRQ_GLOBAL) global_en_reg <= 1'b1; // (RQ18)
			else if (op_mask && cmd_in.kind == mcd_pkg::IRQ_GLOBAL) global_en_reg <= 1'b0;
			if (take_irq) begin
				handler_reg <= 1'b1;
				ret_pc_reg <= prog_pc_in;
				saved_reg <= live_ctx; // (RQ15)
			end else if (op_return_from_handler && handler_reg) begin
				handler_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	wire logic mod_write = act_cmd && cmd_in.opcode == mcd_pkg::OP_WRITE_MODULE_SETTING;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			group_out <= mcd_pkg::MCD_GRP_NONE;
			exec_out <= 1'b0;
			axis_write_out <= 1'b0;
			module_write_out <= 1'b0;
			src_setting_write_out <= 1'b0;
			reply_value_out <= '0;
			reply_valid_out <= 1'b0;
			divert_out <= 1'b0;
			divert_addr_out <= '0;
			resume_out <= 1'b0;
			resume_addr_out <= '0;
		end else begin
			group_out <= is_op_take ? grp : mcd_pkg::MCD_GRP_NONE; // (RQ1) (RQ2)
			exec_out <= act_cmd; // (RQ5)
			axis_write_out <= act_cmd && attr.axis_scope && !attr.reads_value; // (RQ3)
			module_write_out <= act_cmd && attr.module_scope && !attr.reads_value;
			src_setting_write_out <= mod_write && cmd_in.bank == mcd_pkg::IRQ_SETTING_BANK
				&& slot_ok; // (RQ19)
			reply_valid_out <= direct_read; // (RQ9)
			reply_value_out <= direct_read ? read_data_in : reply_value_out;
			divert_out <= take_irq;
			divert_addr_out <= vec_reg[pick_slot < 4'(N) ? pick_slot : 4'h0];
			resume_out <= op_return_from_handler && handler_reg;
			resume_addr_out <= ret_pc_reg;
		end
	end

	assign accu_out = accu_reg;
	assign xreg_out = xreg_reg;
	assign flags_out = flags_reg;
	assign in_handler_out = handler_reg;

	// ****************************************
	// Assertions
	// ****************************************
	a_direct_keeps_accu: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ9)
		direct_read |=> accu_reg == $past(accu_reg))
		else $error("direct read changed accumulator");
	a_no_nesting: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ16)
		handler_reg |-> !take_irq)
		else $error("interrupt dispatched inside handler");
	a_dispatch_cond: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ14)
		take_irq |-> (|(pend_reg & enable_reg & vec_ok_reg)) && global_en_reg)
		else $error("dispatch without enable or vector");
	a_ctx_saved: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ15)
		take_irq |=> saved_reg.accu == $past(accu_reg) && saved_reg.xreg == $past(xreg_reg)
		&& saved_reg.flags == $past(flags_reg))
		else $error("context not saved on dispatch");
	a_ctx_restore: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ17)
		op_return_from_handler && handler_reg |=> accu_reg == $past(saved_reg.accu) && !handler_reg
		&& resume_out)
		else $error("context not restored on return");
	a_stand_read: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ7)
		stand_read && !op_return_from_handler |=> accu_reg == $past(read_data_in))
		else $error("standalone read not in accumulator");
	a_lowest_first: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ20)
		take_irq && ready[0] |-> pick_slot == 4'h0)
		else $error("lower source not served first");
	a_divert_pulse: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ12)
		take_irq |=> divert_out && divert_addr_out == $past(vec_reg[pick_slot]))
		else $error("wrong handler address");
	a_x_load: assert property (@(posedge clock_in) disable iff (rst_in) // (RQ8)
		xload && !(op_return_from_handler && handler_reg) |=> xreg_reg == $past(accu_reg))
		else $error("X register not loaded from accumulator");

endmodule

// file: include/mcd_pkg.sv
// Package with opcodes, interrupt numbers and carrier types of the command decoder.
package mcd_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_ROTATE_RIGHT = 8'h01;
	localparam logic [7:0] OP_ROTATE_LEFT = 8'h02;
	localparam logic [7:0] OP_SOFT_STOP_MOTOR = 8'h03;
	localparam logic [7:0] OP_MOVE_TO_TARGET = 8'h04;
	localparam logic [7:0] OP_WRITE_AXIS_SETTING = 8'h05;
	localparam logic [7:0] OP_READ_AXIS_SETTING = 8'h06;
	localparam logic [7:0] OP_SAVE_AXIS_SETTING_NV = 8'h07;
	localparam logic [7:0] OP_RELOAD_AXIS_SETTING_NV = 8'h08;
	localparam logic [7:0] OP_WRITE_MODULE_SETTING = 8'h09;
	localparam logic [7:0] OP_READ_MODULE_SETTING = 8'h0a;
	localparam logic [7:0] OP_SAVE_MODULE_SETTING_NV = 8'h0b;
	localparam logic [7:0] OP_RELOAD_MODULE_SETTING_NV = 8'h0c;
	localparam logic [7:0] OP_DRIVE_OUTPUT_PORT = 8'h0e;
	localparam logic [7:0] OP_READ_INPUT_PORT = 8'h0f;
	localparam logic [7:0] OP_ARITH_WITH_CONSTANT = 8'h13;
	localparam logic [7:0] OP_TEST_AGAINST_CONSTANT = 8'h14;
	localparam logic [7:0] OP_JUMP_CONDITIONAL = 8'h15;
	localparam logic [7:0] OP_JUMP_ALWAYS = 8'h16;
	localparam logic [7:0] OP_CALL_ROUTINE = 8'h17;
	localparam logic [7:0] OP_RETURN_FROM_ROUTINE = 8'h18;
	localparam logic [7:0] OP_UNMASK_INTERRUPT_SOURCE = 8'h19;
	localparam logic [7:0] OP_MASK_INTERRUPT_SOURCE = 8'h1a;
	localparam logic [7:0] OP_WAIT = 8'h1b;
	localparam logic [7:0] OP_PROGRAM_STOP = 8'h1c;
	localparam logic [7:0] OP_STORE_COORDINATE = 8'h1e;
	localparam logic [7:0] OP_FETCH_COORDINATE = 8'h1f;
	localparam logic [7:0] OP_CAPTURE_COORDINATE = 8'h20;
	localparam logic [7:0] OP_ARITH_WITH_X_REGISTER = 8'h21;
	localparam logic [7:0] OP_ACCU_TO_AXIS_SETTING = 8'h22;
	localparam logic [7:0] OP_ACCU_TO_MODULE_SETTING = 8'h23;
	localparam logic [7:0] OP_SET_HANDLER_ENTRY = 8'h25;
	localparam logic [7:0] OP_RETURN_FROM_HANDLER = 8'h26;
	localparam logic [7:0] OP_ACCU_TO_COORDINATE = 8'h27;

	// ****************************************
	// Interrupt sources
	// ****************************************
	localparam int NUM_SRC = 10;
	localparam logic [7:0] IRQ_GLOBAL = 8'hff;
	localparam logic [7:0] IRQ_SETTING_BANK = 8'h03;
	// Interrupt number of each source slot; slot order is ascending number.
	localparam logic [7:0] IRQ_NUM [NUM_SRC] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f,
		8'h15, 8'h1b, 8'h1c, 8'h27, 8'h28};
	localparam logic [3:0] SLOT_NONE = 4'hf;

	// ****************************************
	// Command groups
	// ****************************************
	typedef enum logic [6:0] {
		MCD_GRP_NONE = 7'h00,
		MCD_GRP_MOTION = 7'h01,
		MCD_GRP_PARAM = 7'h02,
		MCD_GRP_BRANCH = 7'h04,
		MCD_GRP_IO = 7'h08,
		MCD_GRP_ARITH_WITH_CONSTANT = 7'h10,
		MCD_GRP_IRQ = 7'h20,
		MCD_GRP_BAD = 7'h40
	} mcd_group_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] kind;
		logic [7:0] bank;
		logic [31:0] value;
	} mcd_cmd_t;

	typedef struct packed {
		logic [31:0] accu;
		logic [31:0] xreg;
		logic [7:0] flags;
	} mcd_context_t;

	typedef struct packed {
		logic reads_value;
		logic axis_scope;
		logic module_scope;
		logic standalone_only;
	} mcd_attr_t;

endpackage

// file: rtl/mcd_group_decode.sv
// Combinational decoder that sorts an opcode into its command group.
module mcd_group_decode (
	input wire logic [7:0] opcode_in,
	output mcd_pkg::mcd_group_t group_out,
	output mcd_pkg::mcd_attr_t attr_out
);

	always_comb begin
		attr_out = '0;
		case (opcode_in)
			mcd_pkg::OP_ROTATE_RIGHT, mcd_pkg::OP_ROTATE_LEFT, mcd_pkg::OP_SOFT_STOP_MOTOR,
			mcd_pkg::OP_MOVE_TO_TARGET, mcd_pkg::OP_STORE_COORDINATE,
			mcd_pkg::OP_CAPTURE_COORDINATE: group_out = mcd_pkg::MCD_GRP_MOTION; // (RQ1)
			mcd_pkg::OP_FETCH_COORDINATE: begin
				group_out = mcd_pkg::MCD_GRP_MOTION; // (RQ1)
				attr_out.reads_value = 1'b1;
			end
			mcd_pkg::OP_WRITE_AXIS_SETTING, mcd_pkg::OP_SAVE_AXIS_SETTING_NV,
			mcd_pkg::OP_RELOAD_AXIS_SETTING_NV: begin
				group_out = mcd_pkg::MCD_GRP_PARAM; // (RQ2)
				attr_out.axis_scope = 1'b1; // (RQ3)
			end
			mcd_pkg::OP_READ_AXIS_SETTING: begin
				group_out = mcd_pkg::MCD_GRP_PARAM; // (RQ2)
				attr_out.axis_scope = 1'b1;
				attr_out.reads_value = 1'b1;
			end
			mcd_pkg::OP_WRITE_MODULE_SETTING, mcd_pkg::OP_SAVE_MODULE_SETTING_NV,
			mcd_pkg::OP_RELOAD_MODULE_SETTING_NV: begin
				group_out = mcd_pkg::MCD_GRP_PARAM; // (RQ2)
				attr_out.module_scope = 1'b1; // (RQ3)
			end
			mcd_pkg::OP_READ_MODULE_SETTING: begin
				group_out = mcd_pkg::MCD_GRP_PARAM; // (RQ2)
				attr_out.module_scope = 1'b1;
				attr_out.reads_value = 1'b1;
			end
			mcd_pkg::OP_JUMP_ALWAYS, mcd_pkg::OP_JUMP_CONDITIONAL,
			mcd_pkg::OP_TEST_AGAINST_CONSTANT, mcd_pkg::OP_CALL_ROUTINE,
			mcd_pkg::OP_RETURN_FROM_ROUTINE, mcd_pkg::OP_WAIT,
			mcd_pkg::OP_PROGRAM_STOP: begin
				group_out = mcd_pkg::MCD_GRP_BRANCH; // (RQ4)
				attr_out.standalone_only = 1'b1;
			end
			mcd_pkg::OP_DRIVE_OUTPUT_PORT: group_out = mcd_pkg::MCD_GRP_IO; // (RQ5)
			mcd_pkg::OP_READ_INPUT_PORT: begin
				group_out = mcd_pkg::MCD_GRP_IO; // (RQ5)
				attr_out.reads_value = 1'b1;
			end
			mcd_pkg::OP_ARITH_WITH_CONSTANT, mcd_pkg::OP_ARITH_WITH_X_REGISTER,
			mcd_pkg::OP_ACCU_TO_AXIS_SETTING, mcd_pkg::OP_ACCU_TO_MODULE_SETTING,
			mcd_pkg::OP_ACCU_TO_COORDINATE: group_out = mcd_pkg::MCD_GRP_ARITH_WITH_CONSTANT; // (RQ6)
			mcd_pkg::OP_UNMASK_INTERRUPT_SOURCE, mcd_pkg::OP_MASK_INTERRUPT_SOURCE,
			mcd_pkg::OP_SET_HANDLER_ENTRY,
			mcd_pkg::OP_RETURN_FROM_HANDLER: group_out = mcd_pkg::MCD_GRP_IRQ; // (RQ11)
			default: group_out = mcd_pkg::MCD_GRP_BAD;
		endcase
	end

endmodule

// file: rtl/mcd_irq_pick.sv
// Priority picker: the lowest pending, enabled and vectored source wins.
module mcd_irq_pick #(
	parameter int N = 10
) (
	input wire logic [N-1:0] ready_in,
	output logic any_out,
	output logic [3:0] slot_out
);

	always_comb begin
		any_out = 1'b0;
		slot_out = mcd_pkg::SLOT_NONE;
		for (int i = N - 1; i >= 0; i--) begin
			if (ready_in[i]) begin
				any_out = 1'b1; // (RQ20)
				slot_out = 4'(i);
			end
		end
	end

endmodule

// file: tb/mcd_host_model.sv
// Command source model standing for the host and the stored program.
module mcd_host_model (
	input wire logic clock_in,
	output logic cmd_valid_out,
	output logic cmd_direct_out,
	output mcd_pkg::mcd_cmd_t cmd_out,
	output logic [31:0] read_data_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmd_valid_out = 1'b0;
		cmd_direct_out = 1'b0;
		cmd_out = '0;
		read_data_out = 32'h0;
	end

	// Presents one command for one cycle; the data lines carry junk outside that cycle.
	task automatic send(input logic direct, input logic [7:0] op, input logic [7:0] kind,
		input logic [7:0] bank, input logic [31:0] value, input logic [31:0] rdata);
		@(negedge clock_in);
		cmd_valid_out = 1'b1;
		cmd_direct_out = direct;
		cmd_out = '{op, kind, bank, value};
		read_data_out = rdata;
		@(negedge clock_in);
		cmd_valid_out = 1'b0;
		cmd_out.value = ~value;
		read_data_out = ~rdata;
	endtask

	// Vectors a source, enables it and switches on global interrupt processing.
	task automatic arm(input logic [7:0] num, input logic [31:0] entry);
		send(1'b0, mcd_pkg::OP_SET_HANDLER_ENTRY, num, 8'h00, entry, 32'h0);
		send(1'b0, mcd_pkg::OP_UNMASK_INTERRUPT_SOURCE, num, 8'h00, 32'h0, 32'h0);
		send(1'b0, mcd_pkg::OP_UNMASK_INTERRUPT_SOURCE, mcd_pkg::IRQ_GLOBAL, 8'h00, 32'h0, 32'h0);
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking testbench of the command decoder.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock_in;
	logic rst_in;
	logic cmd_valid;
	logic cmd_direct;
	mcd_pkg::mcd_cmd_t cmd;
	logic [31:0] read_data;
	logic [15:0] prog_pc;
	logic [9:0] irq_event;
	mcd_pkg::mcd_group_t group;
	logic exec, axis_write, module_write, src_write, reply_valid, divert, resume, in_handler;
	logic [31:0] reply_value, accu, xreg;
	logic [7:0] flags;
	logic [15:0] divert_addr, resume_addr;
	int bad_count = 0;
	int checks = 0;
	logic [31:0] seed = 32'h326e;

	mcd_host_model u_mcd_host_model (.clock_in(clock_in), .cmd_valid_out(cmd_valid),
		.cmd_direct_out(cmd_direct), .cmd_out(cmd), .read_data_out(read_data));

	mcd_decoder u_mcd_decoder (.clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
		.cmd_direct_in(cmd_direct), .cmd_in(cmd), .read_data_in(read_data),
		.prog_pc_in(prog_pc), .irq_event_in(irq_event), .group_out(group), .exec_out(exec),
		.axis_write_out(axis_write), .module_write_out(module_write),
		.src_setting_write_out(src_write), .reply_value_out(reply_value),
		.reply_valid_out(reply_valid), .accu_out(accu), .xreg_out(xreg), .flags_out(flags),
		.divert_out(divert), .divert_addr_out(divert_addr), .resume_out(resume),
		.resume_addr_out(resume_addr), .in_handler_out(in_handler));

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic mcd_pkg::mcd_group_t exp_group(input logic [7:0] op);
		case (op) inside
			8'h01, 8'h02, 8'h03, 8'h04, 8'h1e, 8'h1f, 8'h20: return mcd_pkg::MCD_GRP_MOTION;
			[8'h05:8'h0c]: return mcd_pkg::MCD_GRP_PARAM;
			8'h0e, 8'h0f: return mcd_pkg::MCD_GRP_IO;
			8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1b, 8'h1c: return mcd_pkg::MCD_GRP_BRANCH;
			8'h13, 8'h21, 8'h22, 8'h23, 8'h27: return mcd_pkg::MCD_GRP_ARITH_WITH_CONSTANT;
			8'h19, 8'h1a, 8'h25, 8'h26: return mcd_pkg::MCD_GRP_IRQ;
			default: return mcd_pkg::MCD_GRP_BAD;
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Pulses the given events and watches a bounded number of cycles, from that one on, for a dispatch.
	task automatic fire(input logic [9:0] ev, input int n, input logic hit_exp,
		input logic [15:0] addr_exp);
		logic hit;
		logic [15:0] addr;
		hit = 1'b0;
		addr = 16'h0;
		@(negedge clock_in);
		irq_event = ev;
		prog_pc = 16'(rnd());
		for (int i = 0; i <= n; i++) begin
			if (divert === 1'b1 && !hit) begin
				hit = 1'b1;
				addr = divert_addr;
			end
			@(negedge clock_in);
			irq_event = 10'h0;
		end
		check("divert", {31'h0, hit_exp}, {31'h0, hit});
		if (hit_exp) begin
			check("divert_addr", {16'h0, addr_exp}, {16'h0, addr});
		end
	endtask

	initial begin
		#2ms;
		bad_count++;
		finish_test();
	end

	initial begin
		logic [31:0] d, e, v, c1, a0, a3;
		logic [15:0] pc;
		mcd_pkg::mcd_group_t g;
		rst_in = 1'b1;
		irq_event = 10'h0;
		prog_pc = 16'h0;
		repeat (8) @(negedge clock_in);
		rst_in = 1'b0;
		check("accu_reset", 32'h0, accu);
		check("group_reset", {25'h0, mcd_pkg::MCD_GRP_NONE}, {25'h0, group});

		for (int op = 0; op < 56; op++) begin
			logic [7:0] o;
			o = (op < 48) ? op[7:0] : 8'(8'h30 + rnd() % 8'hd0);
			g = exp_group(o);
			u_mcd_host_model.send(1'b1, o, 8'h00, 8'h00, rnd(), rnd());
			check("group", {25'h0, g}, {25'h0, group});
			if (g == mcd_pkg::MCD_GRP_BRANCH || g == mcd_pkg::MCD_GRP_BAD) begin
				check("exec_refused", 32'h0, {31'h0, exec});
			end else if (g != mcd_pkg::MCD_GRP_ARITH_WITH_CONSTANT && g != mcd_pkg::MCD_GRP_IRQ) begin
				check("exec_direct", 32'h1, {31'h0, exec});
			end
		end
		$display("decode test done");

		d = rnd();
		e = rnd();
		v = rnd();
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_READ_AXIS_SETTING, 8'h01, 8'h00, 32'h0, d);
		check("accu_read", d, accu);
		u_mcd_host_model.send(1'b1, mcd_pkg::OP_READ_MODULE_SETTING, 8'h02, 8'h00, 32'h0, e);
		check("reply_valid", 32'h1, {31'h0, reply_valid});
		check("reply_value", e, reply_value);
		check("accu_kept", d, accu);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_ARITH_WITH_CONSTANT, 8'h00, 8'h00, v, 32'h0);
		check("accu_add", d + v, accu);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_ARITH_WITH_X_REGISTER, 8'h03, 8'h00, 32'h0, 32'h0);
		check("xreg_load", d + v, xreg);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_WRITE_AXIS_SETTING, 8'h04, 8'h00, v, 32'h0);
		check("axis_write", 32'h2, {30'h0, axis_write, module_write});
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_WRITE_MODULE_SETTING, 8'h00, 8'h03, v, 32'h0);
		check("src_write", 32'h3, {30'h0, module_write, src_write});
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_WRITE_MODULE_SETTING, 8'h05, 8'h03, v, 32'h0);
		check("src_write_bad", 32'h2, {30'h0, module_write, src_write});
		$display("accumulator test done");

		a0 = rnd() & 32'hffff;
		a3 = rnd() & 32'hffff;
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_SET_HANDLER_ENTRY, 8'h0f, 8'h00, rnd(), 32'h0);
		u_mcd_host_model.arm(8'h00, a0);
		u_mcd_host_model.arm(8'h03, a3);
		fire(10'h010, 5, 1'b0, 16'h0);
		c1 = rnd();
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_ARITH_WITH_CONSTANT, 8'h02, 8'h00, c1, 32'h0);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_ARITH_WITH_X_REGISTER, 8'h03, 8'h00, 32'h0, 32'h0);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_TEST_AGAINST_CONSTANT, 8'h00, 8'h00, c1, 32'h0);
		check("zero_flag", 32'h1, {31'h0, flags[0]});
		fire(10'h009, 5, 1'b1, a0[15:0]);
		pc = prog_pc;
		check("in_handler", 32'h1, {31'h0, in_handler});
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_ARITH_WITH_CONSTANT, 8'h02, 8'h00, ~c1, 32'h0);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_TEST_AGAINST_CONSTANT, 8'h00, 8'h00, c1, 32'h0);
		fire(10'h001, 5, 1'b0, 16'h0);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_RETURN_FROM_HANDLER, 8'h00, 8'h00, 32'h0, 32'h0);
		check("resume", {16'h1, pc}, {15'h0, resume, resume_addr});
		check("accu_restored", c1, accu);
		check("xreg_restored", c1, xreg);
		check("flag_restored", 32'h2, {30'h0, flags[0], in_handler});
		fire(10'h000, 5, 1'b1, a0[15:0]);
		u_mcd_host_model.send(1'b0, mcd_pkg::OP_RETURN_FROM_HANDLER, 8'h00, 8'h00, 32'h0, 32'h0);
		check("second_resume", 32'h1, {31'h0, resume});
		check("second_accu", c1, accu);
		fire(10'h000, 5, 1'b1, a3[15:0]);
		$display("interrupt test done");
		finish_test();
	end
endmodule
